/* hdl/sfm_defines.svh */
// Sizes, pointer limits and timing counts of the serial field memory ports.
// Assumes inclusion by the package and the design file only.
`ifndef SFM_DEFINES_SVH
`define SFM_DEFINES_SVH
`define SFM_WORD_W     4
`define SFM_WORDS      6'h3C
`define SFM_LAST_WORD  6'h3B
`define SFM_FETCH_AT   6'h37
`define SFM_BLK_BITS   240
`define SFM_LINE_W     9
`define SFM_BLK_W      4
`define SFM_IDX_W      13
`define SFM_LINES      10'h132
`define SFM_LAST_LINE  9'h131
`define SFM_LAST_BLK   4'hF
`define SFM_NIDX       4896
`define SFM_CLR_DELAY  7'h40
`define SFM_DLY_W      7
`define SFM_TRW_PULSES 3'h5
`define SFM_TRR_PULSES 3'h4
`define SFM_FIFO_DEPTH 16
`endif

/* hdl/sfm_pkg.sv */
// Types shared by the field memory port logic and its FIFO.
// Assumes sfm_defines.svh is on the include path.
`include "sfm_defines.svh"
package sfm_pkg;
  typedef logic [`SFM_LINE_W-1:0]   sfm_line_t;
  typedef logic [`SFM_BLK_W-1:0]    sfm_blk_t;
  typedef logic [`SFM_IDX_W-1:0]    sfm_idx_t;
  typedef logic [`SFM_BLK_BITS-1:0] sfm_data_t;
  typedef logic [5:0]               sfm_cnt_t;
  // Line-clear progress of a read port
  typedef enum logic [2:0] {
    LCS_IDLE  = 3'h1,
    LCS_ARM   = 3'h2,
    LCS_LATCH = 3'h4
  } sfm_lcs_t;
  typedef struct packed {
    sfm_line_t line;
    sfm_blk_t  blk;
  } sfm_ptr_t;
  typedef struct packed {
    sfm_idx_t  idx;
    sfm_data_t data;
  } sfm_blk_entry_t;
  // Every asynchronous input, sampled as one word
  typedef struct packed {
    logic       wclk;
    logic       gate_n;
    logic       lcw;
    logic       bcw;
    logic       lsw;
    logic [3:0] din;
    logic       rec;
    logic       pms;
    logic       mss;
    logic [2:0] syn;
    logic [1:0] rclk;
    logic [1:0] lcr;
    logic [1:0] bcr;
    logic [1:0] lsr;
    logic [1:0] oen;
  } sfm_pins_t;
  typedef struct packed {
    logic      prev_lc;
    logic      prev_bc;
    logic      prev_ls;
    sfm_cnt_t  cnt;
    sfm_data_t shreg;
    sfm_ptr_t  ptr;
    sfm_line_t pend;
    logic      vclr;
    logic [2:0] scnt;
  } sfm_wr_t;
  typedef struct packed {
    logic                  prev_lc;
    logic                  prev_bc;
    logic                  prev_ls;
    sfm_cnt_t              cnt;
    sfm_data_t             shreg;
    sfm_data_t             dreg;
    sfm_ptr_t              ptr;
    sfm_line_t             pend;
    sfm_lcs_t              stage;
    logic [`SFM_DLY_W-1:0] dly;
    logic [3:0]            out;
    logic                  oe;
    logic [2:0]            scnt;
  } sfm_rd_t;
endpackage

/* hdl/sfm_ports.sv */
// Write port, two read ports, FIFO and block array of the field memory.
// Assumes every port pin arrives asynchronously to clk_sys, which must
// run well above all port clocks so that each edge is seen.
`timescale 1ns/100ps
`include "sfm_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Block FIFO between the write shift register and the cell array
module sfm_fifo
  import sfm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SFM_FIFO_DEPTH
) (
  input  wire logic             clk_sys,    // System clock
  input  wire logic             rst,        // Async reset, high
  input  wire logic             in_valid,   // Entry offered
  output logic                  in_ready,   // Room for an entry
  input  wire logic [WIDTH-1:0] in_data,    // Entry in
  output logic                  out_valid,  // Entry waiting
  input  wire logic             out_ready,  // Drain side takes it
  output logic [WIDTH-1:0]      out_data    // Oldest entry
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } sfm_fifo_st_t;
  sfm_fifo_st_t st_ff;
  sfm_fifo_st_t nxt_st;
  logic         push;
  logic         pop;

  // Honest flags straight from the fill count
  assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data  = st_ff.mem[st_ff.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers wrap at DEPTH, so depths need not be powers of two
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = (st_ff.wp == AW'(DEPTH-1)) ? '0 : st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = (st_ff.rp == AW'(DEPTH-1)) ? '0 : st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Write block clear starts block 0 (the preset block in preset mode) with this word, dropping partial block.
// - In recursive mode block clears and line steps are ignored.
// - Clear and step pins count once per low-to-high, per port clock.
// - Write line steps pend until block clear or block fill after line clear.
// - After write line clear, next block goes to line n, block h+1.
// - Write line step with line clear or block clear is not counted.
// - Write block clear after steps moves to line v+n, block 0 or the preset block in preset mode.
// - Each read clock edge samples control pins and shifts out the next word, save the last word held during a clear delay.
// - Recursive read line clear: finish block, line 0 block 0 after 64 clocks.
// - Nonrecursive read line clear: finish, output v,h+1, then line n,h+2.
// - Nonrecursive read block clear: finish block, line v+n block 0 after 64.
// - Read steps apply at block clear or at the clock-56 line latch.
// - Read line clear outputs line n, block h+2; coincident step ignored.
// - Read block clear outputs line v+n; coincident step does count.
// - Write shift register advances only while write gate is low.
// - Full write blocks pass a FIFO into the array a system clock later; a slave waits for the write sync rise.
// - Output enable only floats its own port outputs; nothing stops.
// - Read shift runs without a gate but holds its last word during a clear delay; next block fetched during the current one.
// - Sync pins driven as master, only write sync received as slave, or carry preset.
// - Preset bits form plain binary block number, sel0 least significant.
// - Recursive select high auto-increments; low uses clear and step pins.
// - Array holds 306 lines of 16 blocks of 60 four-bit words.
module sfm_ports
  import sfm_pkg::*;
(
  input  wire logic       clk_sys,             // System clock, 250 MHz
  input  wire logic       rst,                 // Async reset, high
  input  wire logic       write_clock,         // Write port clock pin
  input  wire logic       write_gate_n,        // Write gate, low accepts data
  input  wire logic       line_clear_write,    // Write line clear
  input  wire logic       block_clear_write,   // Write block clear
  input  wire logic       line_step_write,     // Write line step
  input  wire logic [3:0] serial_in,           // Write data word
  input  wire logic       recursive_select,    // High selects recursive mode
  input  wire logic       preset_mode_select,  // High selects block preset
  input  wire logic       master_slave_select, // Low master; preset sel2
  input  wire logic       sync_write_i,        // Write sync pin in; preset sel0
  output logic            sync_write_o,        // Write sync pin out
  output logic            sync_write_oe,       // Write sync pin driven
  input  wire logic       sync_read_a_i,       // Read A sync in; preset sel1
  output logic            sync_read_a_o,       // Read A sync out
  output logic            sync_read_a_oe,      // Read A sync driven
  input  wire logic       sync_read_b_i,       // Read B sync in; preset sel3
  output logic            sync_read_b_o,       // Read B sync out
  output logic            sync_read_b_oe,      // Read B sync driven
  input  wire logic [1:0] read_clock,          // Read clocks, bit 0 port A
  input  wire logic [1:0] line_clear_read,     // Read line clears
  input  wire logic [1:0] block_clear_read,    // Read block clears
  input  wire logic [1:0] line_step_read,      // Read line steps
  input  wire logic [1:0] output_enable_n,     // Read output enables, low
  output logic [3:0]      serial_out_a,        // Read port A data
  output logic            serial_out_a_oe,     // Port A outputs driven
  output logic [3:0]      serial_out_b,        // Read port B data
  output logic            serial_out_b_oe      // Port B outputs driven
);
  typedef struct packed {
    sfm_pins_t                               s1;
    sfm_pins_t                               s2;
    logic                                    wclk_d;
    logic [1:0]                              rclk_d;
    logic [2:0]                              syn_d;
    sfm_wr_t                                 wr;
    sfm_rd_t [1:0]                           rd;
    logic [2:0]                              sout;
    logic                                    soe;
    logic [`SFM_NIDX-1:0][`SFM_BLK_BITS-1:0] mem;
  } sfm_state_t;

  sfm_state_t     st_ff;
  sfm_state_t     nxt_st;
  sfm_pins_t      pins_c;
  sfm_blk_entry_t push_entry;
  sfm_blk_entry_t drain_entry;
  logic           push_c;
  logic           fifo_ready;
  logic           drain_valid;
  logic           drain_ok;

  // 306 lines of 16 blocks
  // Sum of a line and a step count, wrapping past the last line
  function automatic sfm_line_t line_add(input sfm_line_t a, input sfm_line_t b);
    logic [`SFM_LINE_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= `SFM_LINES) begin
      s = s - `SFM_LINES;
    end
    return s[`SFM_LINE_W-1:0];
  endfunction

  // Next block; recursive mode walks the whole field, else stops at 15
  function automatic sfm_ptr_t ptr_next(input sfm_ptr_t p, input logic rec);
    sfm_ptr_t n;
    n = p;
    if (p.blk != `SFM_LAST_BLK) begin
      n.blk = p.blk + 1'b1;
    end else if (rec) begin
      n.blk  = '0;
      n.line = (p.line == `SFM_LAST_LINE) ? '0 : p.line + 1'b1;
    end
    return n;
  endfunction

  // Array index; sixteen blocks per line make it a concatenation
  function automatic sfm_idx_t blk_index(input sfm_ptr_t p);
    return {p.line, p.blk};
  endfunction

  assign pins_c = '{wclk: write_clock, gate_n: write_gate_n, lcw: line_clear_write,
                    bcw: block_clear_write, lsw: line_step_write, din: serial_in,
                    rec: recursive_select, pms: preset_mode_select,
                    mss: master_slave_select,
                    syn: {sync_read_b_i, sync_read_a_i, sync_write_i},
                    rclk: read_clock, lcr: line_clear_read, bcr: block_clear_read,
                    lsr: line_step_read, oen: output_enable_n};

  ////////////////////////////////////////////////////////////////////////////////
  // data register stage
  sfm_fifo #(
    .WIDTH ($bits(sfm_blk_entry_t)),
    .DEPTH (`SFM_FIFO_DEPTH)
  ) u_blk_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (push_c),
    .in_ready  (fifo_ready),
    .in_data   (push_entry),
    .out_valid (drain_valid),
    .out_ready (drain_ok),
    .out_data  (drain_entry)
  );

  // A slave only commits a block on the master's write sync rising edge
  assign drain_ok = ~(~st_ff.s2.pms & st_ff.s2.mss) | (st_ff.s2.syn[0] & ~st_ff.syn_d[0]);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state for both sides of every port
  always_comb begin
    logic      rec;
    logic      lc;
    logic      bc;
    logic      ls;
    logic      take;
    logic      master;
    sfm_blk_t  preset;
    sfm_rd_t   p;
    sfm_data_t blk_d;
    rec    = st_ff.s2.rec;
    lc     = 1'b0;
    bc     = 1'b0;
    ls     = 1'b0;
    take   = 1'b0;
    master = ~st_ff.s2.pms & ~st_ff.s2.mss;
    preset = {st_ff.s2.syn[2], st_ff.s2.mss, st_ff.s2.syn[1], st_ff.s2.syn[0]};
    p      = '0;
    blk_d  = '0;
    nxt_st = st_ff;
    push_c = 1'b0;
    push_entry = '0;
    // Two-flop capture of every pin
    nxt_st.s1     = pins_c;
    nxt_st.s2     = st_ff.s1;
    nxt_st.wclk_d = st_ff.s2.wclk;
    nxt_st.rclk_d = st_ff.s2.rclk;
    nxt_st.syn_d  = st_ff.s2.syn;

    // write logic advances only on write clock edges
    if (st_ff.s2.wclk & ~st_ff.wclk_d) begin
      lc = st_ff.s2.lcw & ~st_ff.wr.prev_lc;
      bc = st_ff.s2.bcw & ~st_ff.wr.prev_bc & ~rec;
      ls = st_ff.s2.lsw & ~st_ff.wr.prev_ls & ~rec & ~lc & ~bc;
      nxt_st.wr.prev_lc = st_ff.s2.lcw;
      nxt_st.wr.prev_bc = st_ff.s2.bcw;
      nxt_st.wr.prev_ls = st_ff.s2.lsw;
      take = ~st_ff.s2.gate_n & fifo_ready;
      if (st_ff.wr.scnt != '0) begin
        nxt_st.wr.scnt = st_ff.wr.scnt - 1'b1;
      end
      if ((lc & rec) | bc) begin
        nxt_st.wr.shreg = '0;
        nxt_st.wr.cnt   = '0;
        nxt_st.wr.ptr.line = rec ? '0 : (lc ? st_ff.wr.pend
                                            : line_add(st_ff.wr.ptr.line, st_ff.wr.pend));
        nxt_st.wr.ptr.blk  = (~rec & st_ff.s2.pms) ? preset : '0;
        nxt_st.wr.pend     = '0;
        nxt_st.wr.vclr     = 1'b0;
        if (take) begin
          nxt_st.wr.shreg[`SFM_WORD_W-1:0] = st_ff.s2.din;
          nxt_st.wr.cnt = 6'h1;
        end
      end else begin
        if (lc) begin
          nxt_st.wr.vclr = 1'b1;
          nxt_st.wr.pend = '0;
        end else if (ls) begin
          nxt_st.wr.pend = st_ff.wr.pend + 1'b1;
        end
        if (take) begin
          blk_d = st_ff.wr.shreg;
          blk_d[st_ff.wr.cnt*`SFM_WORD_W +: `SFM_WORD_W] = st_ff.s2.din;
          nxt_st.wr.shreg = blk_d;
          if (st_ff.wr.cnt == `SFM_LAST_WORD) begin
            push_c = 1'b1;
            push_entry.idx  = blk_index(st_ff.wr.ptr);
            push_entry.data = blk_d;
            nxt_st.wr.cnt   = '0;
            if (master) begin
              nxt_st.wr.scnt = `SFM_TRW_PULSES;
            end
            if (nxt_st.wr.vclr) begin
              nxt_st.wr.ptr.line = nxt_st.wr.pend;
              nxt_st.wr.ptr.blk  = ptr_next(st_ff.wr.ptr, 1'b0).blk;
              nxt_st.wr.pend     = '0;
              nxt_st.wr.vclr     = 1'b0;
            end else begin
              nxt_st.wr.ptr = ptr_next(st_ff.wr.ptr, rec);
            end
          end else begin
            nxt_st.wr.cnt = st_ff.wr.cnt + 1'b1;
          end
        end
      end
    end

    if (drain_valid & drain_ok) begin
      nxt_st.mem[drain_entry.idx] = drain_entry.data;
    end

    for (int i = 0; i < 2; i++) begin
      p = st_ff.rd[i];
      p.oe = ~st_ff.s2.oen[i];
      if (st_ff.s2.rclk[i] & ~st_ff.rclk_d[i]) begin
        lc = st_ff.s2.lcr[i] & ~st_ff.rd[i].prev_lc;
        bc = st_ff.s2.bcr[i] & ~st_ff.rd[i].prev_bc & ~rec;
        ls = st_ff.s2.lsr[i] & ~st_ff.rd[i].prev_ls & ~rec & ~lc;
        p.prev_lc = st_ff.s2.lcr[i];
        p.prev_bc = st_ff.s2.bcr[i];
        p.prev_ls = st_ff.s2.lsr[i];
        if (st_ff.rd[i].scnt != '0) begin
          p.scnt = st_ff.rd[i].scnt - 1'b1;
        end
        if (ls) begin
          p.pend = st_ff.rd[i].pend + 1'b1;
        end
        if (st_ff.rd[i].dly == 7'h1) begin
          p.shreg = st_ff.rd[i].dreg;
          p.cnt   = '0;
          p.out   = st_ff.rd[i].dreg[`SFM_WORD_W-1:0];
          p.dly   = '0;
        end else begin
          if (st_ff.rd[i].dly != '0) begin
            p.dly = st_ff.rd[i].dly - 1'b1;
          end
          if (st_ff.rd[i].cnt != `SFM_LAST_WORD) begin
            p.cnt = st_ff.rd[i].cnt + 1'b1;
            p.out = st_ff.rd[i].shreg[p.cnt*`SFM_WORD_W +: `SFM_WORD_W];
          end else if (st_ff.rd[i].dly == '0) begin
            p.shreg = st_ff.rd[i].dreg;
            p.cnt   = '0;
            p.out   = st_ff.rd[i].dreg[`SFM_WORD_W-1:0];
          end
          // Last word holds while a clear delay runs out
          if ((st_ff.rd[i].dly == '0) && (st_ff.rd[i].cnt == `SFM_FETCH_AT)) begin
            case (st_ff.rd[i].stage)
              LCS_ARM: begin
                p.stage = LCS_LATCH;
              end
              LCS_LATCH: begin
                p.ptr.line = p.pend;
                p.pend     = '0;
                p.stage    = LCS_IDLE;
              end
              default: begin
                p.stage = LCS_IDLE;
              end
            endcase
            p.dreg = st_ff.mem[blk_index(p.ptr)];
            p.ptr  = ptr_next(p.ptr, rec);
            if (master) begin
              p.scnt = `SFM_TRR_PULSES;
            end
          end
        end
        if ((lc & rec) | bc) begin
          p.ptr.line = rec ? '0 : (lc ? p.pend : line_add(st_ff.rd[i].ptr.line, p.pend));
          p.ptr.blk  = '0;
          p.dreg     = st_ff.mem[blk_index(p.ptr)];
          p.ptr      = ptr_next(p.ptr, rec);
          p.dly      = `SFM_CLR_DELAY;
          p.pend     = '0;
          p.stage    = LCS_IDLE;
          if (master) begin
            p.scnt = `SFM_TRR_PULSES;
          end
        end else if (lc) begin
          p.stage = (st_ff.rd[i].cnt >= `SFM_FETCH_AT) ? LCS_LATCH : LCS_ARM;
          p.pend  = '0;
        end
      end
      nxt_st.rd[i] = p;
    end

    nxt_st.soe  = master;
    nxt_st.sout = {nxt_st.rd[1].scnt != '0, nxt_st.rd[0].scnt != '0, nxt_st.wr.scnt != '0};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Single state register; the array reset is wide but keeps sims clean
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.rd[0].stage <= LCS_IDLE;
      st_ff.rd[1].stage <= LCS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs taken straight from the state register
  assign sync_write_o    = st_ff.sout[0];
  assign sync_read_a_o   = st_ff.sout[1];
  assign sync_read_b_o   = st_ff.sout[2];
  assign sync_write_oe   = st_ff.soe;
  assign sync_read_a_oe  = st_ff.soe;
  assign sync_read_b_oe  = st_ff.soe;
  assign serial_out_a    = st_ff.rd[0].out;
  assign serial_out_a_oe = st_ff.rd[0].oe;
  assign serial_out_b    = st_ff.rd[1].out;
  assign serial_out_b_oe = st_ff.rd[1].oe;
endmodule

/* verif/sfm_ports_chk.sv */
// Checker of the field memory port pins: sync pin drive, enables, edges.
// Assumes a bind to sfm_ports and watches only its ports.
`timescale 1ns/100ps
module sfm_ports_chk (
  input wire logic       clk_sys,             // Clock
  input wire logic       rst,                 // Reset
  input wire logic       write_clock,         // Write clock
  input wire logic [1:0] read_clock,          // Read clocks
  input wire logic       preset_mode_select,  // Preset mode
  input wire logic       master_slave_select, // Slave when high
  input wire logic [1:0] output_enable_n,     // Read enables
  input wire logic       sync_write_o,        // Write sync out
  input wire logic       sync_write_oe,       // Write sync driven
  input wire logic       sync_read_a_o,       // A sync out
  input wire logic       sync_read_b_o,       // B sync out
  input wire logic       sync_read_a_oe,      // A sync driven
  input wire logic       sync_read_b_oe,      // B sync driven
  input wire logic [3:0] serial_out_a,        // A word
  input wire logic       serial_out_a_oe,     // A driven
  input wire logic [3:0] serial_out_b,        // B word
  input wire logic       serial_out_b_oe      // B driven
);
  // One domain, so clock and disable are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Sync pin direction, six cycles leave room for the synchronisers
  property p_master;
    (!preset_mode_select && !master_slave_select) [*6] |->
      sync_write_oe && sync_read_a_oe && sync_read_b_oe;
  endproperty
  a_master: assert property (p_master) else $error("sync pin idle as master");
  property p_slave;
    (master_slave_select && !preset_mode_select) [*6] |-> !sync_write_oe && !sync_read_a_oe;
  endproperty
  a_slave: assert property (p_slave) else $error("sync pin driven as slave");
  property p_preset;
    preset_mode_select [*6] |-> !sync_write_oe && !sync_read_b_oe;
  endproperty
  a_preset: assert property (p_preset) else $error("sync pin driven in preset");
  // Each enable follows its own pin only
  property p_oe_a;
    $stable(output_enable_n[0]) [*6] |-> serial_out_a_oe == !output_enable_n[0];
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("port A enable wrong");
  property p_oe_b;
    $stable(output_enable_n[1]) [*6] |-> serial_out_b_oe == !output_enable_n[1];
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("port B enable wrong");
  // Words and pulses move only just after a rise of their own port clock
  property p_edge_a;
    $changed(serial_out_a) |-> $past(read_clock[0], 2) || $past(read_clock[0], 3);
  endproperty
  a_edge_a: assert property (p_edge_a) else $error("port A word off its edge");
  property p_edge_b;
    $changed(serial_out_b) |-> $past(read_clock[1], 2) || $past(read_clock[1], 3);
  endproperty
  a_edge_b: assert property (p_edge_b) else $error("port B word off its edge");
  property p_edge_w;
    $changed(sync_write_o) |-> $past(write_clock, 2) || $past(write_clock, 3);
  endproperty
  a_edge_w: assert property (p_edge_w) else $error("write pulse off its edge");
  property p_edge_ra;
    $changed(sync_read_a_o) |-> $past(read_clock[0], 2) || $past(read_clock[0], 3);
  endproperty
  a_edge_ra: assert property (p_edge_ra) else $error("port A pulse off its edge");
  property p_edge_rb;
    $changed(sync_read_b_o) |-> $past(read_clock[1], 2) || $past(read_clock[1], 3);
  endproperty
  a_edge_rb: assert property (p_edge_rb) else $error("port B pulse off its edge");
  // Main scenarios reached
  c_pulse: cover property ($rose(sync_write_o));
  c_b_on: cover property ($rose(serial_out_b_oe));
  c_slave: cover property (master_slave_select && !preset_mode_select);
endmodule
bind sfm_ports sfm_ports_chk u_chk (.*);

/* verif/sfm_vpc.sv */
// Video controller model: free-running port clocks and pin-level tasks.
// Assumes the bench calls wr and rd; pins change on falling port edges.
`timescale 1ns/100ps
module sfm_vpc (
  output logic            write_clock,       // Write clock
  output logic            write_gate_n,      // Low takes word
  output logic            line_clear_write,  // Write line clear
  output logic            block_clear_write, // Write block clear
  output logic            line_step_write,   // Write line step
  output logic [3:0]      serial_in,         // Write word
  output logic [1:0]      read_clock,        // Read clocks
  output logic [1:0]      line_clear_read,   // Read line clears
  output logic [1:0]      block_clear_read,  // Read block clears
  output logic [1:0]      line_step_read,    // Read line steps
  input  wire logic [3:0] serial_out_a,      // Port A word
  input  wire logic [3:0] serial_out_b       // Port B word
);
  initial begin
    {write_clock, read_clock} = 3'h0;
    {write_gate_n, line_clear_write, block_clear_write, line_step_write} = 4'h8;
    {serial_in, line_clear_read, block_clear_read, line_step_read} = 10'h000;
    // Half-step offset keeps every pin edge off a clk_sys edge
    #0.5;
    fork
      forever #25 write_clock = ~write_clock;
      forever #28 read_clock[0] = ~read_clock[0];
      forever #30 read_clock[1] = ~read_clock[1];
    join
  end
  ////////////////////////////////////////
  // gate and pins held a whole cycle
  task automatic wr(input logic [3:0] d, input logic g, lc, bc, ls);
    @(negedge write_clock);
    {serial_in, write_gate_n, line_clear_write, block_clear_write, line_step_write} =
      {d, g, lc, bc, ls};
  endtask
  // Pins set at a fall, word sampled at the next fall, well after it settles
  task automatic rd(input int p, input logic lc, bc, ls, output logic [3:0] q);
    line_clear_read[p] = lc;
    block_clear_read[p] = bc;
    line_step_read[p] = ls;
    if (p == 1) @(negedge read_clock[1]);
    else @(negedge read_clock[0]);
    q = (p == 1) ? serial_out_b : serial_out_a;
  endtask
endmodule

/* verif/serial_field_memory_ports_test.sv */
// Self-checking bench for the field memory ports with a controller model.
// Assumes design, checker and model files are compiled before it.
`timescale 1ns/100ps
module serial_field_memory_ports_test;
  logic       clk_sys, rst, recursive_select, preset_mode_select, master_slave_select;
  logic       sync_write_i, sync_read_a_i, sync_read_b_i;
  logic [1:0] output_enable_n;
  wire        write_clock, write_gate_n, line_clear_write, block_clear_write;
  wire        line_step_write, serial_out_a_oe, serial_out_b_oe;
  wire [3:0]  serial_in, serial_out_a, serial_out_b;
  wire [1:0]  read_clock, line_clear_read, block_clear_read, line_step_read;
  wire        sync_write_o, sync_write_oe, sync_read_a_o, sync_read_a_oe;
  wire        sync_read_b_o, sync_read_b_oe;
  logic [3:0] exp_q[$];
  int         miscompares = 0;
  int         total_checks = 0;
  int         cycles = 0;

  sfm_ports uut (.*);
  sfm_vpc   u_vpc (.*);

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Hang guard, a clean run needs about 15000 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Sync pin direction for every mode pin pair
  task automatic modes();
    for (int m = 3; m >= 0; m--) begin
      @(posedge clk_sys) #1 {preset_mode_select, master_slave_select} = m[1:0];
      repeat (8) @(posedge clk_sys);
      chk({sync_write_oe, sync_read_a_oe, sync_read_b_oe}, (m == 0) ? 4'h7 : 4'h0);
    end
  endtask
  // Two steps over a partial block that the clear must drop, then a clear
  // with a coincident step, then three random blocks;
  // gated junk words are mixed in and must never land in the array
  task automatic wr_blocks();
    logic [3:0] d;
    exp_q.delete();
    for (int i = -4; i < 180; i++) begin
      d = 4'($urandom);
      if (i < 0) u_vpc.wr(d, 1'b0, 1'b0, 1'b0, i % 2 == 0);
      else begin
        if ($urandom % 4 == 0) u_vpc.wr(~d, 1'b1, 1'b0, 1'b0, 1'b0);
        u_vpc.wr(d, 1'b0, i == 0 && recursive_select,
                 (i == 0 && !recursive_select) || (i == 30 && recursive_select), i == 0);
        if (i < 120) exp_q.push_back(d);
      end
    end
    u_vpc.wr(d, 1'b1, 1'b0, 1'b0, 1'b0);
  endtask
  // One step, then a clear with a coincident step; port B starts disabled
  task automatic rd_blk(input int p);
    logic [3:0] q;
    @(posedge clk_sys) #1 output_enable_n[p] = (p == 1);
    u_vpc.rd(p, 1'b0, 1'b0, 1'b0, q);
    u_vpc.rd(p, 1'b0, 1'b0, 1'b1, q);
    u_vpc.rd(p, 1'b0, 1'b0, 1'b0, q);
    u_vpc.rd(p, recursive_select, !recursive_select, 1'b1, q);
    for (int i = 1; i < 184; i++) begin
      u_vpc.rd(p, 1'b0, 1'b0, 1'b0, q);
      if (i == 40) @(posedge clk_sys) #1 output_enable_n[p] = 1'b0;
      if (i == 30 || i == 63) chk((p == 1) ? serial_out_b_oe : serial_out_a_oe, i == 63 || p == 0);
      if (i >= 64) chk(q, exp_q[i - 64]);
    end
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, recursive_select, preset_mode_select, master_slave_select} = 4'hC;
    {sync_write_i, sync_read_a_i, sync_read_b_i} = 3'h0;
    output_enable_n = 2'h0;
    void'($urandom(71984));
    repeat (8) @(posedge clk_sys);
    #1 rst = 1'b0;
    modes();
    $display("mode pin test done");
    wr_blocks();
    rd_blk(0);
    $display("recursive block test done");
    @(posedge clk_sys) #1 recursive_select = 1'b0;
    wr_blocks();
    rd_blk(0);
    rd_blk(1);
    $display("nonrecursive block test done");
    wrap_up();
  end
endmodule
